/* File: hw/dbi_params.svh */
// constants for the device bus idle state machine: register offsets, field positions,
// reset values and timing counts; assumes a 100 MHz system clock
`ifndef DBI_PARAMS_SVH
`define DBI_PARAMS_SVH

// system clock
`define DBI_CLK_HZ 32'd100_000_000
`define DBI_CLK_NS 10

// most time allowed for any interrupt line change after a strobe negation
`define DBI_INTRQ_MAX_NS 400
`define DBI_INTRQ_CYC (`DBI_INTRQ_MAX_NS / `DBI_CLK_NS)

// most time allowed after reset for ready, and for diagnostic pin release
`define DBI_DRDY_MAX_S 32'd30
`define DBI_DIAG_MAX_S 32'd31
`define DBI_DRDY_CYC (`DBI_DRDY_MAX_S * `DBI_CLK_HZ)
`define DBI_DIAG_CYC (`DBI_DIAG_MAX_S * `DBI_CLK_HZ)

// parallel port register addresses {control block, 3-bit offset}
`define DBI_PA_STATUS 4'h7
`define DBI_PA_COMMAND 4'h7
`define DBI_PA_DEVICE 4'h6
`define DBI_PA_DEVCTL 4'hE

// bit positions in the parallel port data
`define DBI_DEV_BIT 4
`define DBI_NIEN_BIT 1
`define DBI_SRST_BIT 2

// software register byte offsets on the system bus
`define DBI_OFS_CTRL 8'h00
`define DBI_OFS_STAT 8'h04
`define DBI_OFS_TAG 8'h08
`define DBI_OFS_OPS 8'h0C

// control register fields
`define DBI_CTRL_DEV1 0
`define DBI_CTRL_PACKET 1
`define DBI_CTRL_READY 2

// opcode register reset value: {queued write, queued read, service}
`define DBI_OPS_RST 32'h0003_0201

`endif

/* File: hw/dbi_pkg.sv */
// types shared by the device bus idle state machine and its surroundings
package dbi_pkg;

   typedef enum logic [3:0] {
      ST_SI, ST_S, ST_NS, ST_SIR, ST_SR, ST_SIS, ST_SS, ST_NSO, ST_CMD
   } dbi_state_e;

   // completion report from the command protocol engine
   typedef struct packed {
      logic valid;
      logic rel;
      logic serv;
      logic set_ipend;
   } dbi_done_s;

   // hand-off to the command protocol engine
   typedef struct packed {
      logic start;
      logic abort;
      logic service;
      logic [7:0] opcode;
   } dbi_cmd_s;

endpackage

/* File: hw/dbi_idle_fsm.sv */
// device side bus idle state machine with overlapped and queued idle states
// assumes host strobes arrive on pins, a command protocol engine reports completion,
// and software reaches the control registers over AHB-Lite with this as the only slave
//
// Notes on behaviour
// - interrupt-asserted selected idle: BSY, DRQ low, INTRQ high; non-status reads ignored
// - command write there clears pending, drops INTRQ, frees PDIAG-/DASP-, starts command
// - status read or nIEN set there clears INTRQ and moves to selected idle
// - self-select or writes other than command, deselect or device control keep the interrupt-asserted state
// - selecting the other device releases INTRQ and enters not-selected idle
// - selected idle holds BSY, DRQ, INTRQ low; device 0 enters it after reset
// - non-packet device sets DRDY within 30 s after reset; packet device never
// - command write in selected idle ends pending, frees PDIAG-, starts command
// - selected idle stays on other writes, goes not-selected when other device chosen
// - not-selected idle holds BSY, DRQ low, INTRQ released; device 1 enters it
// - non-packet device releases DASP- and PDIAG- within 31 s after reset
// - reselection asserts INTRQ if pending and enabled, else selected idle
// - released overlapped command with pending interrupt: INTRQ high, BSY, DRQ low
// - command write in released interrupt state clears pending and starts command
// - with a queue, non-queued commands abort the queue and report aborted
// - status read in released interrupt state clears INTRQ, goes released negated
// - deselection in released interrupt state releases INTRQ, leaves selection
// - ready to continue in released interrupt state moves to service interrupt state
// - released negated state: outputs low; command starts, deselect to overlapped idle
// - ready to continue from released negated goes service state, INTRQ per nIEN
// - status read in service interrupt state clears INTRQ, goes service negated
// - service command loads the serviced tag, drops INTRQ, resumes that command
// - deselection with release or service pending enters not-selected overlapped idle
`timescale 1ns/1ps
`default_nettype none
`include "dbi_params.svh"

module dbi_idle_fsm
   import dbi_pkg::*;
#(
   parameter logic [31:0] DRDY_CYC = `DBI_DRDY_CYC,
   parameter logic [31:0] DIAG_CYC = `DBI_DIAG_CYC
)
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // parallel host port
   input wire logic dior_n_i,
   input wire logic diow_n_i,
   input wire logic [3:0] host_addr_i,
   input wire logic [7:0] host_wdata_i,
   // open-drain and tristate pins
   output logic intrq_o,
   output logic intrq_oe_o,
   output logic pdiag_n_o,
   output logic pdiag_n_oe_o,
   output logic dasp_n_o,
   output logic dasp_n_oe_o,
   // status bits toward the status register path
   output logic bsy_o,
   output logic drq_o,
   output logic drdy_o,
   output logic [7:0] tag_o,
   // command protocol engine
   input wire dbi_done_s done_i,
   output dbi_cmd_s cmd_o,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o
);

   localparam int INTRQ_MAX = `DBI_INTRQ_CYC;

   dbi_state_e state_r, state_nxt;
   logic dior_s1_r, dior_s2_r, dior_s3_r;
   logic diow_s1_r, diow_s2_r, diow_s3_r;
   logic [11:0] rcap_r, wcap_r;
   logic r_ev, w_ev, r_status, w_cmd, w_dev, w_ctl;
   logic sel_me, sel_other, nien_set, irq_ok;
   logic nien_r, srst_r, ipend_r, svc_pend_r, q_active_r;
   logic dev1_r, packet_r, ready_pulse_r;
   logic [7:0] pend_tag_r;
   logic [23:0] ops_r;
   logic [31:0] start_cnt_r;
   logic drdy_r, diag_drv_r, dasp_drv_r;
   logic soft_rst;
   logic cmd_abort, cmd_service;
   logic ahb_wr_r, ahb_rd_r;
   logic [7:0] ahb_addr_r;

   function automatic logic asserted_state(input dbi_state_e s);
      return (s == ST_SI) || (s == ST_SIR) || (s == ST_SIS);
   endfunction

   function automatic logic selected_state(input dbi_state_e s);
      return (s != ST_NS) && (s != ST_NSO);
   endfunction

   function automatic dbi_state_e done_target(input logic rel, input logic serv, input logic irq);
      if (serv)
         return irq ? ST_SIS : ST_SS;
      else if (rel)
         return irq ? ST_SIR : ST_SR;
      else
         return irq ? ST_SI : ST_S;
   endfunction

   // strobe synchronisers; only the second stage and later feed decisions
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         dior_s1_r <= 1'b1;
         dior_s2_r <= 1'b1;
         dior_s3_r <= 1'b1;
         diow_s1_r <= 1'b1;
         diow_s2_r <= 1'b1;
         diow_s3_r <= 1'b1;
      end
      else
      begin
         dior_s1_r <= dior_n_i;
         dior_s2_r <= dior_s1_r;
         dior_s3_r <= dior_s2_r;
         diow_s1_r <= diow_n_i;
         diow_s2_r <= diow_s1_r;
         diow_s3_r <= diow_s2_r;
      end
   end

   // address and data are held by the host for the whole strobe, so keep the last low sample
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         rcap_r <= 12'h000;
         wcap_r <= 12'h000;
      end
      else
      begin
         if (!dior_n_i)
            rcap_r <= {host_addr_i, host_wdata_i};
         if (!diow_n_i)
            wcap_r <= {host_addr_i, host_wdata_i};
      end
   end

   // negation edges, two cycles after the pin, far inside the 400 ns window
   assign r_ev = dior_s2_r && !dior_s3_r;
   assign w_ev = diow_s2_r && !diow_s3_r;
   assign r_status = r_ev && (rcap_r[11:8] == `DBI_PA_STATUS);
   assign w_cmd = w_ev && (wcap_r[11:8] == `DBI_PA_COMMAND);
   assign w_dev = w_ev && (wcap_r[11:8] == `DBI_PA_DEVICE);
   assign w_ctl = w_ev && (wcap_r[11:8] == `DBI_PA_DEVCTL);
   assign sel_me = w_dev && (wcap_r[`DBI_DEV_BIT] == dev1_r);
   assign sel_other = w_dev && (wcap_r[`DBI_DEV_BIT] != dev1_r);
   assign nien_set = w_ctl && wcap_r[`DBI_NIEN_BIT];
   assign soft_rst = w_ctl && wcap_r[`DBI_SRST_BIT] && !srst_r;
   assign irq_ok = ipend_r && !nien_r;
   assign cmd_service = wcap_r[7:0] == ops_r[7:0];
   // with a queue only queued commands and service are legal
   assign cmd_abort = q_active_r && !cmd_service && (wcap_r[7:0] != ops_r[15:8]) &&
      (wcap_r[7:0] != ops_r[23:16]);

   // device control: nIEN is shared by both devices, so it is taken regardless of selection
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         nien_r <= 1'b0;
         srst_r <= 1'b0;
      end
      else if (w_ctl)
      begin
         nien_r <= wcap_r[`DBI_NIEN_BIT];
         srst_r <= wcap_r[`DBI_SRST_BIT];
      end
   end

   // main state machine; status reads of other registers never reach it
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_SI:
         begin
            if (w_cmd)
               state_nxt = ST_CMD;
            else if (sel_other)
               state_nxt = ST_NS;
            else if (r_status || nien_set)
               state_nxt = ST_S;
         end
         ST_S:
         begin
            if (w_cmd)
               state_nxt = ST_CMD;
            else if (sel_other)
               state_nxt = ST_NS;
         end
         ST_NS:
         begin
            if (sel_me)
               state_nxt = irq_ok ? ST_SI : ST_S;
         end
         ST_SIR:
         begin
            if (w_cmd)
               state_nxt = ST_CMD;
            else if (sel_other)
               state_nxt = ST_NSO;
            else if (ready_pulse_r)
               state_nxt = ST_SIS;
            else if (r_status || nien_set)
               state_nxt = ST_SR;
         end
         ST_SR:
         begin
            if (w_cmd)
               state_nxt = ST_CMD;
            else if (sel_other)
               state_nxt = ST_NSO;
            else if (ready_pulse_r)
               state_nxt = nien_r ? ST_SS : ST_SIS;
         end
         ST_SIS:
         begin
            if (w_cmd)
               state_nxt = ST_CMD;
            else if (sel_other)
               state_nxt = ST_NSO;
            else if (r_status || nien_set)
               state_nxt = ST_SS;
         end
         ST_SS:
         begin
            if (w_cmd)
               state_nxt = ST_CMD;
            else if (sel_other)
               state_nxt = ST_NSO;
         end
         ST_NSO:
         begin
            if (sel_me)
               state_nxt = done_target(1'b1, svc_pend_r, irq_ok);
         end
         ST_CMD:
         begin
            if (done_i.valid)
               state_nxt = done_target(done_i.rel, done_i.serv, done_i.set_ipend && !nien_r);
         end
      endcase
   end

   // resets leave device 0 selected and device 1 deselected
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         state_r <= ST_S;
      else if (soft_rst)
         state_r <= dev1_r ? ST_NS : ST_S;
      else
         state_r <= state_nxt;
   end

   // interrupt pending: a setting event wins over a clear in the same cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || soft_rst)
         ipend_r <= 1'b0;
      else if ((state_r == ST_CMD) && done_i.valid && done_i.set_ipend)
         ipend_r <= 1'b1;
      else if ((state_r == ST_SR) && ready_pulse_r && !nien_r)
         ipend_r <= 1'b1;
      else if (w_cmd && selected_state(state_r))
         ipend_r <= 1'b0;
      else if (r_status && asserted_state(state_r))
         ipend_r <= 1'b0;
   end

   // service and queue bookkeeping for reselection and command screening
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || soft_rst)
      begin
         svc_pend_r <= 1'b0;
         q_active_r <= 1'b0;
      end
      else
      begin
         if (state_nxt == ST_SIS || state_nxt == ST_SS)
            svc_pend_r <= 1'b1;
         else if (state_nxt == ST_CMD)
            svc_pend_r <= 1'b0;
         if ((state_r == ST_CMD) && done_i.valid)
            q_active_r <= done_i.rel || done_i.serv;
         else if (w_cmd && selected_state(state_r) && cmd_abort)
            q_active_r <= 1'b0;
      end
   end

   // command hand-off and serviced tag
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         cmd_o <= '0;
         tag_o <= 8'h00;
      end
      else
      begin
         cmd_o.start <= w_cmd && selected_state(state_r) && !soft_rst;
         if (w_cmd && selected_state(state_r))
         begin
            cmd_o.opcode <= wcap_r[7:0];
            cmd_o.abort <= cmd_abort;
            cmd_o.service <= cmd_service;
            if (cmd_service && (state_r == ST_SIS || state_r == ST_SS))
               tag_o <= pend_tag_r;
         end
      end
   end

   // pin and status outputs follow the next state so they move with it
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         intrq_o <= 1'b0;
         intrq_oe_o <= 1'b0;
         bsy_o <= 1'b0;
      end
      else
      begin
         intrq_o <= asserted_state(state_nxt) && !soft_rst;
         intrq_oe_o <= selected_state(state_nxt) && !nien_r && !soft_rst;
         bsy_o <= (state_nxt == ST_CMD) && !soft_rst;
      end
   end

   // DRQ belongs to the data protocols, never to the idle states
   assign drq_o = 1'b0;

   // startup: drdy and diagnostic pin release after reset, each bounded by its limit
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || soft_rst)
      begin
         start_cnt_r <= 32'h0000_0000;
         drdy_r <= 1'b0;
         diag_drv_r <= 1'b1;
         dasp_drv_r <= 1'b1;
      end
      else
      begin
         if (start_cnt_r != DIAG_CYC)
            start_cnt_r <= start_cnt_r + 32'h0000_0001;
         if (start_cnt_r == DRDY_CYC - 32'h0000_0001 && !packet_r)
            drdy_r <= 1'b1;
         if (start_cnt_r == DIAG_CYC - 32'h0000_0001)
         begin
            diag_drv_r <= 1'b0;
            dasp_drv_r <= 1'b0;
         end
         if (w_cmd && selected_state(state_r))
         begin
            diag_drv_r <= 1'b0;
            if (state_r == ST_SI)
               dasp_drv_r <= 1'b0;
         end
      end
   end

   assign drdy_o = drdy_r;
   assign pdiag_n_o = 1'b0;
   assign pdiag_n_oe_o = diag_drv_r;
   assign dasp_n_o = 1'b0;
   assign dasp_n_oe_o = dasp_drv_r;

   // AHB-Lite slave: zero wait states, always OKAY, unmapped reads as zero
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         ahb_wr_r <= 1'b0;
         ahb_rd_r <= 1'b0;
         ahb_addr_r <= 8'h00;
      end
      else if (hready_i)
      begin
         ahb_wr_r <= hsel_i && htrans_i[1] && hwrite_i;
         ahb_rd_r <= hsel_i && htrans_i[1] && !hwrite_i;
         ahb_addr_r <= haddr_i[7:0];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         dev1_r <= 1'b0;
         packet_r <= 1'b0;
         ready_pulse_r <= 1'b0;
         pend_tag_r <= 8'h00;
         ops_r <= 24'(`DBI_OPS_RST);
      end
      else
      begin
         ready_pulse_r <= 1'b0;
         if (ahb_wr_r)
         begin
            unique case (ahb_addr_r)
               `DBI_OFS_CTRL:
               begin
                  dev1_r <= hwdata_i[`DBI_CTRL_DEV1];
                  packet_r <= hwdata_i[`DBI_CTRL_PACKET];
                  ready_pulse_r <= hwdata_i[`DBI_CTRL_READY];
               end
               `DBI_OFS_TAG: pend_tag_r <= hwdata_i[7:0];
               `DBI_OFS_OPS: ops_r <= hwdata_i[23:0];
               default: ;
            endcase
         end
      end
   end

   // read data is registered in the address phase and stands in the data phase
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         hrdata_o <= 32'h0000_0000;
      else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
      begin
         unique case (haddr_i[7:0])
            `DBI_OFS_CTRL: hrdata_o <= {30'h0000_0000, packet_r, dev1_r};
            `DBI_OFS_STAT: hrdata_o <= {20'h0_0000, dasp_drv_r, diag_drv_r, q_active_r, intrq_o,
               drdy_r, nien_r, ipend_r, svc_pend_r, state_r};
            `DBI_OFS_TAG: hrdata_o <= {16'h0000, tag_o, pend_tag_r};
            `DBI_OFS_OPS: hrdata_o <= {8'h00, ops_r};
            default: hrdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_si_pins: assert property (state_r == ST_SI && !nien_r |-> intrq_o && intrq_oe_o && !bsy_o)
      else $error("asserted idle does not drive interrupt");
   a_cmd_clears_pend: assert property (state_r == ST_SI && w_cmd && !soft_rst |=>
      !ipend_r && !intrq_o && bsy_o && cmd_o.start && !dasp_n_oe_o)
      else $error("command write left interrupt pending");
   a_status_read_si: assert property (state_r == ST_SI && r_status && !w_ev |=>
      state_r == ST_S && !intrq_o && !ipend_r)
      else $error("status read did not clear interrupt");
   a_si_stays: assert property (state_r == ST_SI && w_ev && !w_cmd && !sel_other && !w_ctl |=>
      state_r == ST_SI)
      else $error("asserted idle left on harmless write");
   a_deselect_release: assert property ((state_r == ST_SI || state_r == ST_SIR) && sel_other && !w_cmd |=>
      !intrq_oe_o && (state_r == ST_NS || state_r == ST_NSO))
      else $error("deselection did not release interrupt");
   a_reset_entry: assert property ($past(sys_rst_i) |-> state_r == ST_S && !bsy_o && !intrq_o)
      else $error("reset did not enter selected idle");
   a_packet_drdy: assert property (packet_r && !$past(drdy_r) |-> !drdy_o)
      else $error("packet device set ready");
   a_reselect_irq: assert property (state_r == ST_NS && sel_me && irq_ok && !soft_rst |=>
      state_r == ST_SI && intrq_o)
      else $error("reselection lost pending interrupt");
   a_queue_abort: assert property (state_r == ST_SIR && w_cmd && cmd_abort && !soft_rst |=>
      cmd_o.start && cmd_o.abort && !q_active_r)
      else $error("illegal command did not abort queue");
   a_ready_service: assert property (state_r == ST_SR && ready_pulse_r && !w_ev && !soft_rst |=>
      (state_r == ST_SIS) == !$past(nien_r))
      else $error("ready to continue went to wrong state");
   a_service_tag: assert property (state_r == ST_SIS && w_cmd && cmd_service && !soft_rst |=>
      tag_o == $past(pend_tag_r) && !intrq_o)
      else $error("service did not load tag");
   a_strobe_latency: assert property ($rose(diow_n_i) && !sys_rst_i |-> ##[1:INTRQ_MAX] w_ev)
      else $error("write negation not seen in time");

   c_status_clear: cover property (state_r == ST_SI ##[1:50] state_r == ST_S);
   c_queue_abort: cover property (cmd_o.start && cmd_o.abort);
   c_service_run: cover property (state_r == ST_SIS ##[1:50] cmd_o.start && cmd_o.service);
   c_reselect: cover property (state_r == ST_NSO ##1 state_r == ST_SIR);

endmodule
`default_nettype wire

/* File: verif/dbi_host_model.sv */
// host adapter model: drives the parallel strobes, address and write data
// assumes the bench calls acc() from one process at a time
`timescale 1ns/1ps
`default_nettype none

module dbi_host_model
(
   // clock
   input wire logic clk_i,
   // parallel port pins
   output logic dior_n_o,
   output logic diow_n_o,
   output logic [3:0] addr_o,
   output logic [7:0] data_o
);
   initial
   begin
      dior_n_o = 1'b1;
      diow_n_o = 1'b1;
      addr_o = 4'h0;
      data_o = 8'h00;
   end

   // strobe low 4 cycles, high 5: the device synchroniser needs 3 of each
   // the bench only writes a command in asserted idle when a scenario asks for it
   task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      data_o <= d;
      if (wr)
         diow_n_o <= 1'b0;
      else
         dior_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      dior_n_o <= 1'b1;
      diow_n_o <= 1'b1;
      @(posedge clk_i);
      // lines no longer held show no stale value
      addr_o <= ~a;
      data_o <= ~d;
      repeat (4) @(posedge clk_i);
   endtask
endmodule

`default_nettype wire

/* File: verif/device_bus_idle_fsm_tb.sv */
// self-checking bench for the bus idle state machine
// assumes the host model above and a bench-driven command engine completion
`timescale 1ns/1ps
`default_nettype none
`include "dbi_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t %h %h", $time, (a), (b)); end end

module device_bus_idle_fsm_tb;
   import dbi_pkg::*;
   localparam logic [3:0] A_CMD = `DBI_PA_COMMAND;
   localparam logic [3:0] A_DEV = `DBI_PA_DEVICE;
   localparam logic [3:0] A_DC = `DBI_PA_DEVCTL;
   logic clk, rst, dior_n, diow_n, intrq, intrq_oe, pdiag_oe, dasp_oe, bsy, drq, drdy;
   logic pdiag_n, dasp_n;
   logic [7:0] tg, tag;
   logic hsel, hwrite, hready, hresp;
   logic [3:0] paddr;
   logic [7:0] pdata, op;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   dbi_done_s done;
   dbi_cmd_s cmd;
   int fails, num_checks;

   dbi_host_model HOST (.clk_i(clk), .dior_n_o(dior_n), .diow_n_o(diow_n), .addr_o(paddr), .data_o(pdata));
   dbi_idle_fsm #(.DRDY_CYC(32'd20), .DIAG_CYC(32'd30)) DUT (.sys_clk_i(clk), .sys_rst_i(rst),
      .dior_n_i(dior_n), .diow_n_i(diow_n), .host_addr_i(paddr), .host_wdata_i(pdata),
      .intrq_o(intrq), .intrq_oe_o(intrq_oe), .pdiag_n_o(pdiag_n), .pdiag_n_oe_o(pdiag_oe), .dasp_n_o(dasp_n),
      .dasp_n_oe_o(dasp_oe), .bsy_o(bsy), .drq_o(drq), .drdy_o(drdy), .tag_o(tag), .done_i(done), .cmd_o(cmd),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata));

   function automatic logic exp_irq(input dbi_state_e e);
      return (e == ST_SI) || (e == ST_SIR) || (e == ST_SIS);
   endfunction

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic chk_st(input dbi_state_e e);
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
      `CHK(rd[3:0], e)
      `CHK(intrq, exp_irq(e))
      `CHK({bsy, drq}, {(e == ST_CMD), 1'b0})
   endtask

   // command engine completion pulse
   task automatic fin(input logic rel, input logic serv, input logic ip);
      @(posedge clk);
      done <= {1'b1, rel, serv, ip};
      @(posedge clk);
      done <= '0;
      repeat (2) @(posedge clk);
   endtask

   task automatic stop_test;
      if (fails == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test;
   end

   initial
   begin
      {rst, hsel, hsize} = 5'b1_1_010;
      {done, haddr, htrans, hwrite, hwdata, fails, num_checks} = '0;
      void'($urandom(32'h801d));
      op = 8'h10 | 8'($urandom);
      tg = 8'($urandom);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK({intrq_oe, pdiag_oe, dasp_oe, drdy}, 4'b0110)
      `CHK({pdiag_n, dasp_n, hresp, drq}, 4'b0000)
      chk_st(ST_S);
      ahb(1'b0, 32'h0000_000C, 32'h0);
      `CHK(rd, `DBI_OPS_RST)
      ahb(1'b0, 32'h0000_0040, 32'h0);
      `CHK(rd, 32'h0000_0000)
      repeat (20) @(posedge clk);
      `CHK(drdy, 1'b1)
      HOST.acc(1'b1, A_CMD, op);
      `CHK({bsy, pdiag_oe, cmd.opcode}, {2'b10, op})
      fin(1'b0, 1'b0, 1'b1);
      chk_st(ST_SI);
      HOST.acc(1'b0, A_DEV, 8'($urandom));
      chk_st(ST_SI);
      HOST.acc(1'b1, A_DEV, 8'($urandom) & 8'hEF);
      chk_st(ST_SI);
      HOST.acc(1'b0, A_CMD, 8'h00);
      chk_st(ST_S);
      HOST.acc(1'b1, A_DEV, 8'h10);
      chk_st(ST_NS);
      HOST.acc(1'b1, A_DEV, 8'h00);
      chk_st(ST_S);
      HOST.acc(1'b1, A_CMD, op);
      fin(1'b0, 1'b0, 1'b1);
      HOST.acc(1'b1, A_CMD, op);
      chk_st(ST_CMD);
      fin(1'b0, 1'b0, 1'b1);
      HOST.acc(1'b1, A_DEV, 8'h10);
      `CHK(intrq_oe, 1'b0)
      chk_st(ST_NS);
      HOST.acc(1'b1, A_DEV, 8'h00);
      chk_st(ST_SI);
      HOST.acc(1'b1, A_DC, 8'h02);
      `CHK(intrq_oe, 1'b0)
      chk_st(ST_S);
      HOST.acc(1'b1, A_DC, 8'h00);
      // overlapped and queued path
      HOST.acc(1'b1, A_CMD, op);
      fin(1'b1, 1'b0, 1'b1);
      chk_st(ST_SIR);
      ahb(1'b1, 32'h0000_0000, 32'h0000_0004);
      chk_st(ST_SIS);
      HOST.acc(1'b0, A_CMD, 8'h00);
      chk_st(ST_SS);
      ahb(1'b1, 32'h0000_0008, {24'h00_0000, tg});
      HOST.acc(1'b1, A_CMD, 8'h01);
      `CHK({cmd.service, cmd.abort, tag}, {2'b10, tg})
      ahb(1'b0, 32'h0000_0008, 32'h0);
      `CHK(rd[15:0], {tg, tg})
      fin(1'b1, 1'b0, 1'b0);
      chk_st(ST_SR);
      ahb(1'b1, 32'h0000_0000, 32'h0000_0004);
      chk_st(ST_SIS);
      HOST.acc(1'b1, A_DEV, 8'h10);
      chk_st(ST_NSO);
      `CHK(intrq_oe, 1'b0)
      HOST.acc(1'b1, A_DEV, 8'h00);
      HOST.acc(1'b1, A_CMD, op);
      `CHK(cmd.abort, 1'b1)
      // device 1 through software reset
      ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
      HOST.acc(1'b1, A_DC, 8'h04);
      HOST.acc(1'b1, A_DC, 8'h00);
      chk_st(ST_NS);
      `CHK({pdiag_oe, dasp_oe, drdy}, 3'b110)
      repeat (30) @(posedge clk);
      `CHK({pdiag_oe, dasp_oe, drdy}, 3'b001)
      // packet device never reports ready after a reset
      ahb(1'b1, 32'h0000_0000, 32'h0000_0003);
      HOST.acc(1'b1, A_DC, 8'h04);
      HOST.acc(1'b1, A_DC, 8'h00);
      repeat (30) @(posedge clk);
      `CHK({drdy, intrq_oe}, 2'b00)
      stop_test;
   end
endmodule

`default_nettype wire
